// *** core/sld_core.sv ***
// Display core: command parser, display memory, scan and blink timing
module sld_core
    import sld_pkg::*;
#(
    parameter int POR_CNT = POR_CYCLES,
    parameter int OSC_DIVIDE = OSC_DIV,
    parameter int BLINK_FAST_HALF = BLINK_2HZ_HALF,
    parameter int BLINK_MID_HALF = BLINK_1HZ_HALF,
    parameter int BLINK_SLOW_HALF = BLINK_HALF_HZ_HALF
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Link byte stream
    input wire sld_link_in_t link_in,
    output logic link_ready,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // Panel drive
    output logic [3:0] backplane_line,
    output logic [3:0] shared_line,
    output logic [NUM_COLUMNS-1:SHARED_PINS] drive_column,
    output logic shared_as_backplane,
    output logic column19_is_column,
    output logic outputs_at_rail,
    // Analogue control
    output logic [3:0] drive_level_code,
    output logic level_adjust_on,
    output logic rail_sense_on,
    output logic bias_gen_on,
    output logic bias_quarter,
    output logic internal_tick_rate,
    output sld_cfg_t cfg_state
);

    typedef enum logic [1:0] {ST_CMD, ST_PARAM, ST_DATA, ST_SKIP} sld_parse_t;

    generate
        if (OSC_DIVIDE < 2 || OSC_DIVIDE >= (1 << DIV_W) || BLINK_SLOW_HALF >= (1 << DIV_W) ||
            BLINK_FAST_HALF < 1 || POR_CNT < 1)
        begin : g_check
            $error("sld_core: timing parameter out of range");
        end
    endgenerate

    localparam logic [DIV_W-1:0] OSC_M1 = DIV_W'(OSC_DIVIDE - 1);
    localparam logic [DIV_W-1:0] PH_SLOW4_M1 = DIV_W'(FRAME_SLOW_TICKS / 4 - 1);
    localparam logic [DIV_W-1:0] PH_SLOW8_M1 = DIV_W'(FRAME_SLOW_TICKS / 8 - 1);
    localparam logic [DIV_W-1:0] PH_FAST4_M1 = DIV_W'(FRAME_FAST_TICKS / 4 - 1);
    localparam logic [DIV_W-1:0] PH_FAST8_M1 = DIV_W'(FRAME_FAST_TICKS / 8 - 1);
    localparam logic [DIV_W-1:0] BL_FAST_M1 = DIV_W'(BLINK_FAST_HALF - 1);
    localparam logic [DIV_W-1:0] BL_MID_M1 = DIV_W'(BLINK_MID_HALF - 1);
    localparam logic [DIV_W-1:0] BL_SLOW_M1 = DIV_W'(BLINK_SLOW_HALF - 1);
    localparam int POR_W = $clog2(POR_CNT + 1);
    localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CNT - 1);

    logic [7:0] mem [MEM_DEPTH];
    logic [POR_W-1:0] por_cnt_reg;
    logic clearing_reg;
    sld_parse_t state_reg;
    logic [7:0] cmd_reg;
    logic [PTR_W-1:0] ptr_reg;
    logic [7:0] sys_reg, mode_reg, frame_reg, blink_reg, level_reg;
    logic [2:0] phase_reg;
    logic blink_hide_reg;
    logic osc_tick, phase_tick, blink_tick;
    logic osc_on, disp_on, duty8, blink_on;
    logic [DIV_W-1:0] phase_m1, blink_m1;
    logic [2:0] phase_last;
    logic accept;
    logic data_wr, data_rd;
    logic [NUM_COLUMNS-1:0] col_bits;
    logic [7:0] bp_bits;

    // Power-up clear: link refused and pins at rail until the count ends
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            por_cnt_reg <= '0;
            clearing_reg <= 1'b1;
        end
        else if (clearing_reg)
        begin
            por_cnt_reg <= por_cnt_reg + 1'b1;
            if (por_cnt_reg == POR_LAST)
                clearing_reg <= 1'b0;
        end
    end

    // Bytes are only taken once the clear is over; early traffic is dropped
    assign link_ready = !clearing_reg;
    assign accept = !clearing_reg;

    // Command parser: opcode, then parameter, then optional data stream
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= ST_CMD;
            cmd_reg <= 8'h00;
        end
        else if (accept && (link_in.start || link_in.stop))
            state_reg <= ST_CMD;
        else if (accept && link_in.wr_valid)
        begin
            case (state_reg)
                ST_CMD:
                begin
                    cmd_reg <= link_in.wr_data;
                    if (link_in.wr_data == CMD_DATA || link_in.wr_data == CMD_MODE ||
                        link_in.wr_data == CMD_SYS || link_in.wr_data == CMD_FRAME ||
                        link_in.wr_data == CMD_BLINK || link_in.wr_data == CMD_LEVEL)
                        state_reg <= ST_PARAM;
                    else
                        state_reg <= ST_SKIP; // Unknown opcode: ignore to end of transfer
                end
                ST_PARAM:
                    state_reg <= (cmd_reg == CMD_DATA) ? ST_DATA : ST_CMD;
                ST_DATA:
                    state_reg <= ST_DATA;
                ST_SKIP:
                    state_reg <= ST_SKIP;
                default:
                    state_reg <= ST_CMD;
            endcase
        end
    end

    // Configuration bytes, each captured from its command's parameter
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sys_reg <= SYS_RESET;
            mode_reg <= MODE_RESET;
            frame_reg <= FRAME_RESET;
            blink_reg <= BLINK_RESET;
            level_reg <= LEVEL_RESET;
        end
        else if (accept && link_in.wr_valid && !link_in.start && !link_in.stop && state_reg == ST_PARAM)
        begin
            case (cmd_reg)
                CMD_SYS: sys_reg <= link_in.wr_data;
                CMD_MODE: mode_reg <= link_in.wr_data;
                CMD_FRAME: frame_reg <= link_in.wr_data;
                CMD_BLINK: blink_reg <= link_in.wr_data;
                CMD_LEVEL: level_reg <= link_in.wr_data;
                default: ;
            endcase
        end
    end

    assign data_wr = accept && link_in.wr_valid && !link_in.start && !link_in.stop && state_reg == ST_DATA;
    assign data_rd = accept && link_in.rd_req && !link_in.start && !link_in.stop;

    // Address pointer: loaded by the data command, stepped per byte
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            ptr_reg <= PTR_RESET;
        else if (accept && link_in.wr_valid && !link_in.start && !link_in.stop && state_reg == ST_PARAM &&
                 cmd_reg == CMD_DATA)
            ptr_reg <= link_in.wr_data[PTR_W-1:0];
        else if (data_wr || data_rd)
            ptr_reg <= ptr_reg + 1'b1;
    end

    // Display memory; only the link path writes it, beyond 0x0f is dropped
    always_ff @(posedge sys_clk)
    begin
        if (data_wr && ptr_reg < PTR_W'(MEM_DEPTH))
            mem[ptr_reg[3:0]] <= link_in.wr_data;
    end

    // Read answer, one cycle after the request; unmapped reads give zero
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= data_rd;
            if (data_rd)
                rd_data <= (ptr_reg < PTR_W'(MEM_DEPTH)) ? mem[ptr_reg[3:0]] : 8'h00;
        end
    end

    // Decoded controls: display needs the oscillator running as well
    assign osc_on = sys_reg[SYS_OSC_BIT];
    assign disp_on = sys_reg[SYS_OSC_BIT] & sys_reg[SYS_DISP_BIT];
    assign duty8 = mode_reg[MODE_DUTY_BIT];
    assign blink_on = blink_reg[1:0] != BLINK_OFF;
    assign phase_last = duty8 ? 3'h7 : 3'h3;

    // Oscillator model: tick at the 32kHz rate, halted while disabled
    sld_tick_div #(.WIDTH(DIV_W)) u_osc (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .en(osc_on),
        .clr(!osc_on),
        .period_m1(OSC_M1),
        .tick(osc_tick)
    );

    // Backplane step length in oscillator ticks for the frame rate and duty
    always_comb
    begin
        case ({frame_reg[FRAME_FAST_BIT], duty8})
            2'h0: phase_m1 = PH_SLOW4_M1;
            2'h1: phase_m1 = PH_SLOW8_M1;
            2'h2: phase_m1 = PH_FAST4_M1;
            default: phase_m1 = PH_FAST8_M1;
        endcase
    end

    sld_tick_div #(.WIDTH(DIV_W)) u_phase (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .en(osc_tick),
        .clr(!disp_on),
        .period_m1(phase_m1),
        .tick(phase_tick)
    );

    // Blink half period selection
    always_comb
    begin
        case (blink_reg[1:0])
            BLINK_2HZ: blink_m1 = BL_FAST_M1;
            BLINK_1HZ: blink_m1 = BL_MID_M1;
            BLINK_HALF_HZ: blink_m1 = BL_SLOW_M1;
            default: blink_m1 = BL_FAST_M1;
        endcase
    end

    sld_tick_div #(.WIDTH(DIV_W)) u_blink (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .en(osc_tick && blink_on),
        .clr(!blink_on),
        .period_m1(blink_m1),
        .tick(blink_tick)
    );

    // Active backplane index; wraps after four or eight steps
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            phase_reg <= 3'h0;
        else if (!disp_on || phase_reg > phase_last)
            phase_reg <= 3'h0;
        else if (phase_tick)
            phase_reg <= (phase_reg == phase_last) ? 3'h0 : phase_reg + 1'b1;
    end

    // Blink alternates shown and blanked; starts shown whenever re-enabled
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            blink_hide_reg <= 1'b0;
        else if (!blink_on)
            blink_hide_reg <= 1'b0;
        else if (blink_tick)
            blink_hide_reg <= !blink_hide_reg;
    end

    // Memory-to-column mapping for the active backplane
    always_comb
    begin
        col_bits = '0;
        for (int c = 0; c < NUM_COLUMNS; c++)
        begin
            if (!duty8)
            begin
                if (c / 2 < QUARTER_BYTES)
                    col_bits[c] = mem[c / 2][(c % 2) * NIBBLE_W + int'(phase_reg[1:0])];
            end
            else if (c >= SHARED_PINS)
                col_bits[c] = mem[c - SHARED_PINS][phase_reg];
        end
    end

    // One-hot backplane select
    always_comb
    begin
        bp_bits = '0;
        bp_bits[phase_reg] = 1'b1;
    end

    // Pin drive; the slight lag behind phase is hidden by the slow scan
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            backplane_line <= 4'hf;
            shared_line <= 4'hf;
            drive_column <= '1;
        end
        else if (clearing_reg)
        begin
            backplane_line <= 4'hf;
            shared_line <= 4'hf;
            drive_column <= '1;
        end
        else if (!disp_on || blink_hide_reg)
        begin
            backplane_line <= 4'h0;
            shared_line <= 4'h0;
            drive_column <= '0;
        end
        else
        begin
            backplane_line <= bp_bits[3:0];
            shared_line <= duty8 ? bp_bits[7:4] : col_bits[SHARED_PINS-1:0];
            drive_column <= col_bits[NUM_COLUMNS-1:SHARED_PINS];
        end
    end

    // Status and analogue controls, all from flip-flops
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            shared_as_backplane <= 1'b0;
            column19_is_column <= 1'b1;
            outputs_at_rail <= 1'b1;
            drive_level_code <= 4'h0;
            level_adjust_on <= 1'b1;
            rail_sense_on <= 1'b0;
            bias_gen_on <= 1'b0;
            bias_quarter <= 1'b0;
            internal_tick_rate <= 1'b0;
            cfg_state <= '0;
        end
        else
        begin
            shared_as_backplane <= duty8;
            column19_is_column <= level_reg[LEVEL_DE_BIT];
            outputs_at_rail <= clearing_reg;
            drive_level_code <= level_reg[3:0];
            level_adjust_on <= level_reg[LEVEL_VE_BIT];
            rail_sense_on <= !level_reg[LEVEL_DE_BIT] && level_reg[LEVEL_VE_BIT];
            bias_gen_on <= disp_on;
            bias_quarter <= mode_reg[MODE_BIAS_BIT];
            internal_tick_rate <= osc_tick;
            cfg_state <= '{osc_on: osc_on, disp_on: disp_on, duty_eighth: duty8,
                           bias_quarter: mode_reg[MODE_BIAS_BIT], frame_fast: frame_reg[FRAME_FAST_BIT],
                           blink: blink_reg[1:0], column19_sel: level_reg[LEVEL_DE_BIT],
                           level_adjust_on: level_reg[LEVEL_VE_BIT], drive_level_code: level_reg[3:0]};
        end
    end

endmodule : sld_core

// *** common/sld_pkg.sv ***
// Package of constants and types for the segment LCD display core
// Summary of operation
// - Memory holds 16x8 or 20x4 packed nibbles.
// - Quarter mode: byte covers even/odd column pair.
// - Eighth mode: byte drives one column 4-19.
// - Shared pins: columns 0-3 or backplanes 4-7.
// - Memory reached only through link commands.
// - Address advances after each data byte.
// - Frame rate divided from 32kHz oscillator tick.
// - System command starts/stops oscillator; low power.
// - Oscillator stays halted until host enables it.
// - Four-bit drive-level code, default zero.
// - Clear sets quarter duty, one-third bias.
// - Clear: oscillator, bias off, display blanked.
// - Clear: adjust on, pin is column, sensing off.
// - Clear: 80Hz frame, blinking off.
// - Frame command selects 80Hz or 160Hz.
// - During clear all drive pins sit at rail.
// - System byte: bit1 oscillator, bit0 display.
// - Frame byte bit0 doubles rate, default zero.
// - Blink field: off, 2Hz, 1Hz, 0.5Hz.
// - Data command: six-bit start address, default zero.
package sld_pkg;

    // Command opcodes (first byte of a command)
    localparam logic [7:0] CMD_DATA = 8'h80;
    localparam logic [7:0] CMD_MODE = 8'h82;
    localparam logic [7:0] CMD_SYS = 8'h84;
    localparam logic [7:0] CMD_FRAME = 8'h86;
    localparam logic [7:0] CMD_BLINK = 8'h88;
    localparam logic [7:0] CMD_LEVEL = 8'h8a;

    // Memory geometry
    localparam int MEM_DEPTH = 16;
    localparam int QUARTER_BYTES = 10;
    localparam int NUM_COLUMNS = 20;
    localparam int SHARED_PINS = 4;
    localparam int PTR_W = 6;
    localparam logic [5:0] PTR_RESET = 6'h00;

    // Second-byte field positions
    localparam int SYS_OSC_BIT = 1;
    localparam int SYS_DISP_BIT = 0;
    localparam int MODE_DUTY_BIT = 1;
    localparam int MODE_BIAS_BIT = 0;
    localparam int FRAME_FAST_BIT = 0;
    localparam int LEVEL_DE_BIT = 5;
    localparam int LEVEL_VE_BIT = 4;
    localparam int NIBBLE_W = 4;

    // Reset values of the command second bytes
    localparam logic [7:0] SYS_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] FRAME_RESET = 8'h00;
    localparam logic [7:0] BLINK_RESET = 8'h00;
    localparam logic [7:0] LEVEL_RESET = 8'h30;

    // Blink field encodings
    localparam logic [1:0] BLINK_OFF = 2'h0;
    localparam logic [1:0] BLINK_2HZ = 2'h1;
    localparam logic [1:0] BLINK_1HZ = 2'h2;
    localparam logic [1:0] BLINK_HALF_HZ = 2'h3;

    // Timing
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int OSC_HZ = 32_000;
    localparam int OSC_DIV = SYS_CLK_HZ / OSC_HZ;
    localparam int POR_US = 1000;
    localparam int POR_CYCLES = (POR_US * (SYS_CLK_HZ / 1_000_000));
    localparam int FRAME_SLOW_HZ = 80;
    localparam int FRAME_FAST_HZ = 160;
    localparam int FRAME_SLOW_TICKS = OSC_HZ / FRAME_SLOW_HZ;
    localparam int FRAME_FAST_TICKS = OSC_HZ / FRAME_FAST_HZ;
    // Blink half periods in oscillator ticks (shown, then blanked)
    localparam int BLINK_2HZ_HALF = OSC_HZ / 4;
    localparam int BLINK_1HZ_HALF = OSC_HZ / 2;
    localparam int BLINK_HALF_HZ_HALF = OSC_HZ;
    localparam int DIV_W = 16;

    // Configuration state as seen by the host
    typedef struct packed {
        logic osc_on;
        logic disp_on;
        logic duty_eighth;
        logic bias_quarter;
        logic frame_fast;
        logic [1:0] blink;
        logic column19_sel;
        logic level_adjust_on;
        logic [3:0] drive_level_code;
    } sld_cfg_t;

    // Byte stream from the link front end
    typedef struct packed {
        logic start;
        logic stop;
        logic wr_valid;
        logic [7:0] wr_data;
        logic rd_req;
    } sld_link_in_t;

endpackage : sld_pkg

// *** core/sld_tick_div.sv ***
// Enable divider producing a one-cycle tick every period_m1+1 enables
module sld_tick_div
    import sld_pkg::*;
#(
    parameter int WIDTH = DIV_W
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Control
    input wire logic en,
    input wire logic clr,
    input wire logic [WIDTH-1:0] period_m1,
    // Result
    output logic tick
);

    logic [WIDTH-1:0] cnt_reg;

    generate
        if (WIDTH < 2)
        begin : g_check
            $error("sld_tick_div: WIDTH too small");
        end
    endgenerate

    // Count enables; a shrunken period restarts cleanly from zero
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            cnt_reg <= '0;
        else if (clr)
            cnt_reg <= '0;
        else if (en)
            cnt_reg <= (cnt_reg >= period_m1) ? '0 : cnt_reg + 1'b1;
    end

    assign tick = en && !clr && (cnt_reg >= period_m1);

endmodule : sld_tick_div

// *** testbench/sld_core_properties.sv ***
// Port-level assertions for the display core
module sld_core_properties
    import sld_pkg::*;
#(
    parameter int POR_CNT = POR_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire sld_link_in_t link_in,
    input wire logic link_ready,
    input wire logic rd_valid,
    input wire logic [3:0] backplane_line,
    input wire logic [3:0] shared_line,
    input wire logic [NUM_COLUMNS-1:SHARED_PINS] drive_column,
    input wire logic shared_as_backplane,
    input wire logic column19_is_column,
    input wire logic outputs_at_rail,
    input wire logic level_adjust_on,
    input wire logic rail_sense_on,
    input wire logic bias_gen_on,
    input wire logic internal_tick_rate,
    input wire sld_cfg_t cfg_state
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // Edges spent in clear
    int clr_cnt;
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn)
            clr_cnt <= 0;
        else if (!link_ready)
            clr_cnt <= clr_cnt + 1;

    a_rail_drive: assert property (outputs_at_rail |-> &backplane_line && &shared_line && &drive_column)
        else $error("drive pins not at rail during clear");
    a_rail_release: assert property ($rose(link_ready) |=> !outputs_at_rail)
        else $error("rail hold outlasts clear");
    a_clear_length: assert property ($rose(link_ready) |-> clr_cnt >= POR_CNT - 1 && clr_cnt <= POR_CNT + 2)
        else $error("power-up clear length wrong");
    a_blank_off: assert property (!outputs_at_rail && !bias_gen_on |->
        {backplane_line, shared_line, drive_column} == '0) else $error("panel energized while off");
    a_bias_needs_osc: assert property (bias_gen_on |-> cfg_state.osc_on && cfg_state.disp_on)
        else $error("bias on without oscillator and display");
    a_tick_needs_osc: assert property (internal_tick_rate |-> cfg_state.osc_on || $past(cfg_state.osc_on))
        else $error("tick while oscillator halted");
    a_tick_divided: assert property (internal_tick_rate |=> !internal_tick_rate)
        else $error("tick not divided down");
    a_read_answer: assert property (link_ready && link_in.rd_req && !link_in.start && !link_in.stop |=> rd_valid)
        else $error("read request not answered");
    a_read_cause: assert property (rd_valid |-> $past(link_in.rd_req) && $past(link_ready))
        else $error("read answer without request");
    a_shared_role: assert property (shared_as_backplane == cfg_state.duty_eighth)
        else $error("shared pin role differs from duty");
    a_sense_pin: assert property (rail_sense_on == (level_adjust_on && !column19_is_column))
        else $error("rail sensing wrong for pin role");

    c_read: cover property ($rose(rd_valid));
    c_eighth: cover property (shared_as_backplane && bias_gen_on && shared_line != 4'h0);
    c_blink: cover property (bias_gen_on && backplane_line == 4'h0 && cfg_state.blink != 2'h0);
endmodule : sld_core_properties

bind sld_core sld_core_properties #(.POR_CNT(POR_CNT)) i_sld_core_properties (.sys_clk, .rstn, .link_in,
    .link_ready, .rd_valid, .backplane_line, .shared_line, .drive_column, .shared_as_backplane,
    .column19_is_column, .outputs_at_rail, .level_adjust_on, .rail_sense_on, .bias_gen_on,
    .internal_tick_rate, .cfg_state);

// *** testbench/sld_host_model.sv ***
// Host controller model issuing decoded link transfers
module sld_host_model
    import sld_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Link
    input wire logic link_ready,
    output sld_link_in_t link_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial link_in = '0;

    // One link cycle; idle data shows the inverse of the previous cycle's data
    task automatic cyc(input logic st, input logic sp, input logic wv, input logic [7:0] d, input logic rr);
        @(posedge sys_clk);
        link_in <= '{start: st, stop: sp, wr_valid: wv, wr_data: wv ? d : ~link_in.wr_data, rd_req: rr};
    endtask : cyc

    // Whole transfer; gap idle cycles per byte model a slow host
    task automatic xfer(input logic [7:0] b[$], input int gap);
        while (link_ready !== 1'b1) @(negedge sys_clk);
        cyc(1, 0, 0, 8'h00, 0);
        foreach (b[i])
        begin
            repeat (gap) cyc(0, 0, 0, 8'h00, 0);
            cyc(0, 0, 1, b[i], 0);
        end
        cyc(0, 1, 0, 8'h00, 0);
        cyc(0, 0, 0, 8'h00, 0);
    endtask : xfer

    // Back-to-back reads from wherever the pointer stands
    task automatic rd(input int n);
        repeat (n) cyc(0, 0, 0, 8'h00, 1);
        cyc(0, 0, 0, 8'h00, 0);
    endtask : rd
endmodule : sld_host_model

// *** testbench/testbench.sv ***
// Self-checking bench for the display core
module testbench
    import sld_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int POR = 20;
    localparam int DIV = 4;
    localparam int LIMIT = 60000;
    logic sys_clk, rstn, link_ready, rd_valid, shared_as_backplane, column19_is_column, outputs_at_rail;
    logic level_adjust_on, rail_sense_on, bias_gen_on, bias_quarter, internal_tick_rate;
    logic [7:0] rd_data;
    logic [3:0] backplane_line, shared_line, drive_level_code;
    logic [NUM_COLUMNS-1:SHARED_PINS] drive_column;
    sld_link_in_t link_in;
    sld_cfg_t cfg_state;
    int seed = 73711;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc_cnt = 0;
    logic [7:0] mem_exp [16];
    logic [7:0] rd_q [$];

    sld_core #(.POR_CNT(POR), .OSC_DIVIDE(DIV), .BLINK_FAST_HALF(3), .BLINK_MID_HALF(4), .BLINK_SLOW_HALF(5))
        i_sld_core (.sys_clk, .rstn, .link_in, .link_ready, .rd_data, .rd_valid, .backplane_line, .shared_line,
        .drive_column, .shared_as_backplane, .column19_is_column, .outputs_at_rail, .drive_level_code,
        .level_adjust_on, .rail_sense_on, .bias_gen_on, .bias_quarter, .internal_tick_rate, .cfg_state);
    sld_host_model i_sld_host_model (.sys_clk, .link_ready, .link_in);

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // Hang guard
    always @(posedge sys_clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == LIMIT)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    // Read answers stand a full cycle; sample them mid-cycle
    always @(negedge sys_clk)
        if (rd_valid === 1'b1)
            check("rd_data", rd_data, rd_q.size() ? rd_q.pop_front() : 8'hxx);

    // Two-byte command with a random host pace
    task automatic cmd(input logic [7:0] op, input logic [7:0] prm);
        i_sld_host_model.xfer({op, prm}, $unsigned($random(seed)) % 3);
        repeat (2) @(negedge sys_clk);
    endtask : cmd

    function automatic logic col_bit(input logic eighth, input int p, input int c);
        if (eighth)
            return mem_exp[c-4][p];
        return mem_exp[c/2][(c%2)*4+p];
    endfunction : col_bit

    // Cycles while the backplanes (do not) equal v, capped
    task automatic run_len(input logic [3:0] v, input logic eq, output int n);
        n = 0;
        while ((backplane_line === v) == eq && n < 3000)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask : run_len

    // Compare all columns in every scan phase
    task automatic scan_check(input logic eighth);
        int t;
        for (int p = 0; p < (eighth ? 8 : 4); p++)
        begin
            t = 0;
            while (!(eighth ? {shared_line, backplane_line} === 8'(1 << p) : backplane_line === 4'(1 << p))
                && t < 3000)
            begin
                @(negedge sys_clk);
                t++;
            end
            check("phase_seen", t < 3000, 1);
            for (int c = (eighth ? 4 : 0); c < NUM_COLUMNS; c++)
                check("column", c < 4 ? shared_line[c] : drive_column[c], col_bit(eighth, p, c));
        end
    endtask : scan_check

    initial
    begin
        logic [7:0] b [$];
        int n, a;
        rstn = 1'b0;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (POR - 2) @(posedge sys_clk);
        @(negedge sys_clk);
        check("ready_early", link_ready, 0);
        check("rail", {outputs_at_rail, backplane_line, shared_line, drive_column}, 25'h1ffffff);
        repeat (2) @(negedge sys_clk);
        check("ready_late", link_ready, 1);
        repeat (2) @(negedge sys_clk);
        check("cfg_reset", cfg_state, 32'h30);
        check("pins_reset", {column19_is_column, level_adjust_on, rail_sense_on, bias_gen_on, drive_level_code},
            8'hc0);
        n = 0;
        repeat (40) @(negedge sys_clk) n += internal_tick_rate;
        check("halted_ticks", n, 0);
        // Fill memory, then wrap the pointer through dropped slots
        b = {CMD_DATA, 8'h00};
        for (int i = 0; i < MEM_DEPTH; i++)
        begin
            mem_exp[i] = 8'($random(seed));
            b.push_back(mem_exp[i]);
        end
        i_sld_host_model.xfer(b, 0);
        i_sld_host_model.xfer({CMD_DATA, 8'hfe, 8'h11, 8'h22, 8'h33}, 1);
        mem_exp[0] = 8'h33;
        for (int k = 0; k < 3; k++)
        begin
            a = k == 0 ? 14 : $unsigned($random(seed)) % 16;
            i_sld_host_model.xfer({CMD_DATA, 8'(a)}, k);
            for (int i = a; i < a + 4; i++)
                rd_q.push_back(i < MEM_DEPTH ? mem_exp[i] : 8'h00);
            i_sld_host_model.rd(4);
        end
        repeat (4) @(negedge sys_clk);
        check("reads_left", rd_q.size(), 0);
        for (int s = 0; s < 4; s++)
        begin
            cmd(CMD_SYS, 8'(s));
            check("bias_on", bias_gen_on, s == 3);
            check("osc_on", cfg_state.osc_on, s >> 1);
        end
        repeat (4)
        begin
            a = $unsigned($random(seed)) % 64;
            cmd(CMD_LEVEL, 8'(a));
            check("level", {column19_is_column, level_adjust_on, drive_level_code}, a[5:0]);
        end
        cmd(CMD_MODE, 8'h00);
        scan_check(1'b0);
        for (int f = 0; f < 2; f++)
        begin
            cmd(CMD_FRAME, 8'(f));
            run_len(4'h1, 1'b1, n);
            run_len(4'h1, 1'b0, n);
            run_len(4'h1, 1'b1, n);
            check("phase_len", n, (f ? 50 : 100) * DIV);
        end
        cmd(CMD_MODE, 8'h03);
        check("mode8", {shared_as_backplane, bias_quarter}, 2'b11);
        scan_check(1'b1);
        cmd(CMD_MODE, 8'h00);
        check("mode4", shared_as_backplane, 0);
        for (int k = 1; k < 4; k++)
        begin
            cmd(CMD_BLINK, 8'(k));
            run_len(4'h0, 1'b1, n);
            run_len(4'h0, 1'b0, n);
            run_len(4'h0, 1'b1, n);
            check("blank_len", n, (k + 2) * DIV);
        end
        cmd(CMD_BLINK, 8'h00);
        run_len(4'h0, 1'b0, n);
        check("no_blink", n, 3000);
        cmd(CMD_SYS, 8'h00);
        check("off", {backplane_line, shared_line, drive_column}, 0);
        @(posedge sys_clk);
        rstn <= 1'b0;
        @(negedge sys_clk);
        check("rail_again", {outputs_at_rail, link_ready, backplane_line}, 6'h2f);
        rstn <= 1'b1;
        end_of_test();
    end
endmodule : testbench
